// [rtl/csf_pkg.sv]
package csf_pkg;

  // field positions of the processor flags register
  localparam int CSF_WIDTH      = 8;
  localparam int CSF_BIT_CARRY  = 0;
  localparam int CSF_BIT_HALF   = 1;
  localparam int CSF_BIT_ZERO   = 2;
  localparam int CSF_BIT_WRAP   = 3;
  localparam int CSF_BIT_SLEEP  = 4;
  localparam int CSF_BIT_WDOG   = 5;

  // register offset within the special function space (own choice)
  localparam logic [7:0] CSF_FLAGS_OFFSET = 8'h0A;

  // reset values and the read value of the unused bits
  localparam logic CSF_WDOG_RESET  = 1'b0;
  localparam logic CSF_SLEEP_RESET = 1'b0;
  localparam logic CSF_ARITH_RESET = 1'b0;
  localparam logic [1:0] CSF_UNUSED_READ = 2'h0;

  // alu operations
  typedef enum logic [3:0] {
    CSF_OP_NONE  = 4'b0000,
    CSF_OP_ADD   = 4'b0001,
    CSF_OP_ADC   = 4'b0010,
    CSF_OP_SUB   = 4'b0011,
    CSF_OP_SBC   = 4'b0100,
    CSF_OP_AND   = 4'b0101,
    CSF_OP_OR    = 4'b0110,
    CSF_OP_XOR   = 4'b0111,
    CSF_OP_RLC   = 4'b1000,
    CSF_OP_RRC   = 4'b1001,
    CSF_OP_INC   = 4'b1010,
    CSF_OP_DEC   = 4'b1011,
    CSF_OP_PASS  = 4'b1100
  } csf_op_type;

  typedef struct packed {
    logic wrap;
    logic zero;
    logic half;
    logic carry;
  } csf_arith_type;

  typedef struct packed {
    logic wrap_en;
    logic zero_en;
    logic half_en;
    logic carry_en;
  } csf_update_type;

endpackage : csf_pkg

// [rtl/csf_alu.sv]
`timescale 1ns/1ps
`default_nettype none
module csf_alu
  import csf_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // operands
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  input  wire csf_op_type       op_sel,
  input  wire logic             carry_in,
  // results
  output logic [WIDTH-1:0]      result,
  output var csf_arith_type     flags,
  output var csf_update_type    update
);

  if (WIDTH < 5) begin : g_width_check
    $error("width must leave a high nibble");
  end

  wire logic             is_sub   = (op_sel == CSF_OP_SUB) ||
                                    (op_sel == CSF_OP_SBC) ||
                                    (op_sel == CSF_OP_DEC);
  wire logic             use_cin  = (op_sel == CSF_OP_ADC) ||
                                    (op_sel == CSF_OP_SBC);
  wire logic [WIDTH-1:0] b_eff    = (op_sel == CSF_OP_INC) ? WIDTH'(1) :
                                    (op_sel == CSF_OP_DEC) ? WIDTH'(1) : op_b;
  // subtraction as a plus not b plus one, so carry means no borrow
  wire logic [WIDTH-1:0] b_arith  = is_sub ? ~b_eff : b_eff;
  wire logic             cin      = use_cin ? carry_in : is_sub;
  wire logic [4:0]       low_sum  = {1'b0, op_a[3:0]} + {1'b0, b_arith[3:0]}
                                    + {4'h0, cin};
  wire logic [WIDTH-1:0] low_part = {1'b0, op_a[WIDTH-2:0]}
                                    + {1'b0, b_arith[WIDTH-2:0]}
                                    + {{(WIDTH-1){1'b0}}, cin};
  wire logic [WIDTH:0]   full_sum = {1'b0, op_a} + {1'b0, b_arith}
                                    + {{WIDTH{1'b0}}, cin};
  wire logic             msb_in   = low_part[WIDTH-1];
  wire logic             is_arith = (op_sel inside {CSF_OP_ADD, CSF_OP_ADC,
                                    CSF_OP_SUB, CSF_OP_SBC, CSF_OP_INC,
                                    CSF_OP_DEC});
  wire logic             is_rot   = (op_sel == CSF_OP_RLC) ||
                                    (op_sel == CSF_OP_RRC);

  always_comb begin
    result = full_sum[WIDTH-1:0];
    unique case (op_sel)
      CSF_OP_AND:  result = op_a & op_b;
      CSF_OP_OR:   result = op_a | op_b;
      CSF_OP_XOR:  result = op_a ^ op_b;
      CSF_OP_RLC:  result = {op_a[WIDTH-2:0], carry_in}; // see RL11
      CSF_OP_RRC:  result = {carry_in, op_a[WIDTH-1:1]}; // see RL11
      CSF_OP_PASS: result = op_a;
      CSF_OP_NONE: result = op_a;
      default:     result = full_sum[WIDTH-1:0];
    endcase
  end

  assign flags.zero  = (result == '0); // see RL8
  assign flags.wrap  = msb_in ^ full_sum[WIDTH]; // see RL7
  assign flags.half  = low_sum[4]; // see RL9
  assign flags.carry = is_rot ? ((op_sel == CSF_OP_RLC) ? op_a[WIDTH-1]
                                                        : op_a[0])
                              : full_sum[WIDTH]; // see RL10, RL11
  // inc and dec touch only zero; logic ops touch only zero
  wire logic full_arith = is_arith && (op_sel != CSF_OP_INC) &&
                          (op_sel != CSF_OP_DEC);
  assign update.zero_en  = (op_sel != CSF_OP_NONE) && !is_rot &&
                           (op_sel != CSF_OP_PASS);
  assign update.wrap_en  = full_arith;
  assign update.half_en  = full_arith;
  assign update.carry_en = full_arith || is_rot;

endmodule : csf_alu
`default_nettype wire

// [rtl/csf_sysflags.sv]
`timescale 1ns/1ps
`default_nettype none
module csf_sysflags
  import csf_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // events
  input  wire logic watchdog_timeout,
  input  wire logic watchdog_kick_instr,
  input  wire logic sleep_instr,
  // flags
  output logic      watchdog_expiry_flag,
  output logic      sleep_entry_flag
);

  logic wdog_reg;
  logic wdog_next;
  logic sleep_reg;
  logic sleep_next;

  // time-out wins over a same-cycle kick so the event is not lost
  assign wdog_next  = watchdog_timeout ? 1'b1 :
                      (watchdog_kick_instr || sleep_instr) ? 1'b0 :
                      wdog_reg; // see RL3, RL4
  assign sleep_next = sleep_instr ? 1'b1 :
                      watchdog_kick_instr ? 1'b0 :
                      sleep_reg; // see RL5, RL6

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wdog_reg  <= CSF_WDOG_RESET; // see RL16
      sleep_reg <= CSF_SLEEP_RESET; // see RL16
    end else begin
      wdog_reg  <= wdog_next;
      sleep_reg <= sleep_next;
    end
  end

  assign watchdog_expiry_flag = wdog_reg;
  assign sleep_entry_flag     = sleep_reg;

endmodule : csf_sysflags
`default_nettype wire

// [rtl/csf_flags.sv]
// Behaviour
// RL1: an 8-bit flags register holds four arithmetic and two system flags.
// RL2: register writes reach the arithmetic flags but never the system flags.
// RL3: watchdog expiry (bit 5) moves only at reset, time-out, kick or sleep.
// RL4: watchdog expiry sets on time-out and clears at reset, kick or sleep.
// RL5: sleep entry (bit 4) moves only at reset, sleep or kick.
// RL6: sleep entry sets on sleep and clears at reset or kick.
// RL7: wrap (bit 3) is the carry into the top bit xor the carry out of it.
// RL8: zero (bit 2) is 1 exactly when the result is zero.
// RL9: half carry (bit 1): low nibble carry out, or no borrow in subtraction.
// RL10: carry (bit 0): carry out, or no borrow in subtraction.
// RL11: rotates through carry shift out into carry and shift carry in.
// RL12: bits 7 and 6 are unimplemented and read as zero.
// RL13: the four arithmetic flags follow the latest operation affecting them.
// RL14: the flags are not saved automatically on interrupt entry or call.
// RL15: an instruction that does not affect a flag leaves it unchanged.
// RL16: after power-on reset watchdog expiry and sleep entry are zero.
`timescale 1ns/1ps
`default_nettype none
module csf_flags
  import csf_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic [7:0]            reg_rdata,
  // alu operation
  input  wire logic [WIDTH-1:0] alu_a,
  input  wire logic [WIDTH-1:0] alu_b,
  input  wire csf_op_type       alu_op,
  input  wire logic             alu_valid,
  output logic [WIDTH-1:0]      alu_result,
  // system events
  input  wire logic             watchdog_timeout,
  input  wire logic             watchdog_kick_instr,
  input  wire logic             sleep_instr,
  // flag outputs
  output logic [7:0]            processor_flags
);

  if (WIDTH != CSF_WIDTH) begin : g_width_check
    $error("flags datapath must be 8 bits wide");
  end

  csf_arith_type         arith_reg;
  csf_arith_type         arith_next;
  logic [7:0]            rdata_reg;
  logic [WIDTH-1:0]      result_reg;
  csf_arith_type         alu_flags;
  csf_update_type        alu_update;
  logic [WIDTH-1:0]      alu_comb;
  logic                  wdog_flag;
  logic                  sleep_flag;

  csf_alu #(.WIDTH(WIDTH)) csf_alu_inst (
    .op_a     (alu_a),
    .op_b     (alu_b),
    .op_sel   (alu_op),
    .carry_in (arith_reg.carry),
    .result   (alu_comb),
    .flags    (alu_flags),
    .update   (alu_update)
  );

  csf_sysflags csf_sysflags_inst (
    .clock                (clock),
    .rstn                 (rstn),
    .watchdog_timeout     (watchdog_timeout),
    .watchdog_kick_instr  (watchdog_kick_instr),
    .sleep_instr          (sleep_instr),
    .watchdog_expiry_flag (wdog_flag),
    .sleep_entry_flag     (sleep_flag)
  );

  wire logic hit     = (reg_addr == CSF_FLAGS_OFFSET);
  wire logic wr_hit  = reg_write && hit;
  wire logic rd_hit  = reg_read && hit;
  wire logic do_alu  = alu_valid && (alu_op != CSF_OP_NONE);

  // alu flag updates take priority over a same-cycle write for the flags the op affects; a core never does both
  always_comb begin
    arith_next = arith_reg; // see RL15
    if (wr_hit) begin
      arith_next.wrap  = reg_wdata[CSF_BIT_WRAP]; // see RL2
      arith_next.zero  = reg_wdata[CSF_BIT_ZERO];
      arith_next.half  = reg_wdata[CSF_BIT_HALF];
      arith_next.carry = reg_wdata[CSF_BIT_CARRY];
    end
    if (do_alu) begin
      if (alu_update.wrap_en) arith_next.wrap = alu_flags.wrap; // see RL13
      if (alu_update.zero_en) arith_next.zero = alu_flags.zero; // see RL13
      if (alu_update.half_en) arith_next.half = alu_flags.half; // see RL13
      if (alu_update.carry_en) arith_next.carry = alu_flags.carry; // see RL13
    end
  end

  // arithmetic flags are undefined at power-up; cleared here for clean sim
  always_ff @(posedge clock) begin
    if (!rstn) begin
      arith_reg  <= '{default: CSF_ARITH_RESET};
      result_reg <= '0;
    end else begin
      arith_reg <= arith_next;
      if (do_alu) result_reg <= alu_comb;
    end
  end

  // packed view; no save path to any stack exists here
  wire logic [7:0] flags_view = {CSF_UNUSED_READ, wdog_flag, sleep_flag,
                                 arith_reg.wrap, arith_reg.zero,
                                 arith_reg.half, arith_reg.carry};
  // see RL1, RL12, RL14

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_hit ? flags_view : 8'h00;
    end
  end

  assign reg_rdata       = rdata_reg;
  assign alu_result      = result_reg;
  assign processor_flags = flags_view;

endmodule : csf_flags
`default_nettype wire

// [dv/csf_flags_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module csf_flags_asserts
  import csf_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // events and flags
  input wire logic       alu_valid,
  input wire logic       watchdog_timeout,
  input wire logic       watchdog_kick_instr,
  input wire logic       sleep_instr,
  input wire logic [7:0] processor_flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_wr;
    reg_write && reg_addr == CSF_FLAGS_OFFSET;
  endsequence
  sequence s_rd;
    reg_read && reg_addr == CSF_FLAGS_OFFSET;
  endsequence
  AST_WDOG_SET:
    assert property (watchdog_timeout |=> processor_flags[5])
    else $error("watchdog flag not set");
  AST_WDOG_CLR:
    assert property ((watchdog_kick_instr || sleep_instr) &&
      !watchdog_timeout |=> !processor_flags[5])
    else $error("watchdog flag not cleared");
  AST_WDOG_HOLD:
    assert property (!(watchdog_timeout || watchdog_kick_instr ||
      sleep_instr) |=> $stable(processor_flags[5]))
    else $error("watchdog flag moved");
  AST_PD_SET:
    assert property (sleep_instr |=> processor_flags[4])
    else $error("sleep flag not set");
  AST_PD_CLR:
    assert property (watchdog_kick_instr && !sleep_instr
      |=> !processor_flags[4])
    else $error("sleep flag not cleared");
  AST_WRITE:
    assert property (s_wr ##0 !alu_valid
      |=> processor_flags[3:0] == $past(reg_wdata[3:0]))
    else $error("flag write lost");
  AST_ARITH_HOLD:
    assert property (!alu_valid && !reg_write
      |=> $stable(processor_flags[3:0]))
    else $error("arithmetic flags moved");
  AST_READ_VIEW:
    assert property (s_rd |=> reg_rdata == $past(processor_flags))
    else $error("read data wrong");
  AST_READ_ZERO:
    assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule : csf_flags_asserts
bind csf_flags csf_flags_asserts csf_flags_asserts_inst (
  .clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .alu_valid, .watchdog_timeout, .watchdog_kick_instr,
  .sleep_instr, .processor_flags
);
`default_nettype wire

// [dv/csf_flags_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module csf_flags_tb
  import csf_pkg::*;
;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00;
  csf_op_type alu_op = CSF_OP_NONE;
  logic       alu_valid = 1'b0;
  logic [2:0] evt = 3'h0;
  logic [7:0] reg_rdata;
  logic [7:0] alu_result;
  logic [7:0] processor_flags;
  logic [7:0] rd_val;
  int         err_count = 0;
  int         n_compared = 0;
  csf_flags csf_flags_inst (
    .clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .alu_a, .alu_b, .alu_op, .alu_valid, .alu_result,
    .watchdog_timeout(evt[2]), .watchdog_kick_instr(evt[1]),
    .sleep_instr(evt[0]), .processor_flags
  );
  initial forever #20 clock = ~clock;
  task automatic results;
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic do_reset(input int n);
    rstn <= 1'b0;
    repeat (n) @(posedge clock);
    rstn <= 1'b1;
    #1;
  endtask : do_reset
  // every task ends 1 ns past an edge so outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic op(input csf_op_type o, input logic [7:0] a, r,
                    input logic [3:0] f);
    @(posedge clock);
    alu_op <= o;
    alu_a <= a;
    alu_b <= (o == CSF_OP_ADD || o == CSF_OP_SUB) ? 8'h01 : 8'h20;
    alu_valid <= 1'b1;
    @(posedge clock);
    alu_valid <= 1'b0;
    #1;
    `CHK(processor_flags[3:0], f)
    `CHK(alu_result, r)
  endtask : op
  task automatic ev(input logic [2:0] e, input logic [1:0] f);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= 3'h0;
    #1;
    `CHK(processor_flags[5:4], f)
  endtask : ev
  task automatic t_reset;
    `CHK(processor_flags, 8'h00)
    rd(CSF_FLAGS_OFFSET);
    `CHK(rd_val, 8'h00)
  endtask : t_reset
  task automatic t_write;
    wr(CSF_FLAGS_OFFSET, 8'hFF);
    `CHK(processor_flags, 8'h0F)
    rd(CSF_FLAGS_OFFSET);
    `CHK(rd_val, 8'h0F)
    wr(8'h0B, 8'h00);
    rd(8'h0B);
    `CHK(rd_val, 8'h00)
    `CHK(processor_flags, 8'h0F)
  endtask : t_write
  task automatic t_sys;
    ev(3'h4, 2'h2);
    wr(CSF_FLAGS_OFFSET, 8'h00);
    `CHK(processor_flags, 8'h20)
    ev(3'h1, 2'h1);
    ev(3'h2, 2'h0);
    ev(3'h6, 2'h2);
    ev(3'h3, 2'h1);
    @(posedge clock);
    do_reset(2);
    `CHK(processor_flags, 8'h00)
  endtask : t_sys
  // second operand is 01 for ADD and SUB, 20 otherwise
  task automatic t_arith;
    op(CSF_OP_ADD, 8'h7F, 8'h80, 4'hA);
    op(CSF_OP_ADD, 8'hFF, 8'h00, 4'h7);
    op(CSF_OP_ADC, 8'h10, 8'h31, 4'h0);
    op(CSF_OP_SUB, 8'h10, 8'h0F, 4'h1);
    op(CSF_OP_SUB, 8'h80, 8'h7F, 4'h9);
    op(CSF_OP_SBC, 8'h21, 8'h01, 4'h3);
    op(CSF_OP_AND, 8'h40, 8'h00, 4'h7);
    op(CSF_OP_OR, 8'h01, 8'h21, 4'h3);
    op(CSF_OP_XOR, 8'h20, 8'h00, 4'h7);
    op(CSF_OP_INC, 8'hFF, 8'h00, 4'h7);
    op(CSF_OP_DEC, 8'h00, 8'hFF, 4'h3);
    op(CSF_OP_RLC, 8'h00, 8'h01, 4'h2);
    op(CSF_OP_RRC, 8'h01, 8'h00, 4'h3);
    op(CSF_OP_PASS, 8'hFF, 8'hFF, 4'h3);
    op(CSF_OP_NONE, 8'h00, 8'hFF, 4'h3);
  endtask : t_arith
  initial begin
    do_reset(20);
    t_reset();
    t_write();
    t_sys();
    t_arith();
    results();
  end
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    results();
  end
endmodule : csf_flags_tb
`default_nettype wire
